// ===== verilog/pic_pkg.sv
// package of constants for the priority interrupt controller
package pic_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] PIC_PRIMARY_ENABLE_OFS   = 8'h00;
  localparam logic [7:0] PIC_PRIMARY_PRIORITY_OFS = 8'h04;
  localparam logic [7:0] PIC_SECONDARY_OFS        = 8'h08;
  localparam logic [7:0] PIC_WATCHDOG_CFG_OFS     = 8'h0c;
  localparam logic [7:0] PIC_STATUS_OFS           = 8'h10;

  // reset values
  localparam logic [7:0] PIC_PRIMARY_ENABLE_RST   = 8'h00;
  localparam logic [7:0] PIC_PRIMARY_PRIORITY_RST = 8'h00;
  localparam logic [7:0] PIC_SECONDARY_RST        = 8'ha0;
  localparam logic [7:0] PIC_WATCHDOG_CFG_RST     = 8'h00;

  // secondary enable/priority register fields
  localparam int PIC_SEC_RSVD_HI_BIT   = 7;
  localparam int PIC_SEC_TIC_PRI_BIT   = 6;
  localparam int PIC_SEC_PSM_PRI_BIT   = 5;
  localparam int PIC_SEC_SPI_PRI_BIT   = 4;
  localparam int PIC_SEC_RSVD_LO_BIT   = 3;
  localparam int PIC_SEC_TIC_EN_BIT    = 2;
  localparam int PIC_SEC_PSM_EN_BIT    = 1;
  localparam int PIC_SEC_SPI_EN_BIT    = 0;
  localparam logic [7:0] PIC_SEC_WRITE_MASK = 8'h77;

  // primary enable and priority register fields (same layout in both)
  localparam int PIC_PRI_EXT0_BIT      = 0;
  localparam int PIC_PRI_TIMER0_BIT    = 1;
  localparam int PIC_PRI_EXT1_BIT      = 2;
  localparam int PIC_PRI_TIMER1_BIT    = 3;
  localparam int PIC_PRI_UART_BIT      = 4;
  localparam int PIC_PRI_TIMER2_BIT    = 5;
  localparam int PIC_PRI_ADC_BIT       = 6;
  localparam int PIC_PRI_GLOBAL_BIT    = 7;
  localparam logic [7:0] PIC_PRIO_WRITE_MASK = 8'h7f;

  // watchdog configuration fields
  localparam int PIC_WD_SELECT_BIT     = 0;
  localparam int PIC_WD_TIMEOUT_LSB    = 4;
  localparam int PIC_WD_TIMEOUT_W      = 4;
  localparam logic [7:0] PIC_WD_WRITE_MASK = 8'hf1;

  // sources in polling order, index 0 served first
  localparam int PIC_NSRC     = 11;
  localparam int PIC_SRC_PSM  = 0;
  localparam int PIC_SRC_WDOG = 1;
  localparam int PIC_SRC_EXT0 = 2;
  localparam int PIC_SRC_ADC  = 3;
  localparam int PIC_SRC_T0   = 4;
  localparam int PIC_SRC_EXT1 = 5;
  localparam int PIC_SRC_T1   = 6;
  localparam int PIC_SRC_SPI  = 7;
  localparam int PIC_SRC_UART = 8;
  localparam int PIC_SRC_T2   = 9;
  localparam int PIC_SRC_TIC  = 10;

  // vector addresses indexed by polling position
  localparam logic [15:0] PIC_VECTORS [PIC_NSRC] = '{
    16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
    16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};

  // axi response codes
  localparam logic [1:0] PIC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PIC_RESP_SLVERR = 2'b10;

  // dispatch sequencer states
  typedef enum logic [1:0] {
    PIC_IDLE  = 2'b00,
    PIC_OFFER = 2'b01,
    PIC_PUSH  = 2'b10,
    PIC_LOAD  = 2'b11
  } pic_state_type;

endpackage

// ===== verilog/pic_priority_interrupt_controller.sv
// priority interrupt controller with axi4-lite register slave
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - secondary bit 6 sets interval counter priority, 1 high, 0 low.
// - secondary bit 5 sets supply monitor priority, 1 high, 0 low.
// - secondary bit 4 sets spi priority, 1 high, 0 low.
// - secondary bit 2 enables the interval counter interrupt.
// - secondary bit 1 enables the supply monitor interrupt.
// - secondary bit 0 enables the spi interrupt.
// - a high priority request preempts a low priority service routine.
// - simultaneous requests of both levels dispatch the high one first.
// - a request never preempts a routine running at its own level.
// - same-level ties follow the fixed polling order, supply monitor first.
// - acceptance pushes the program counter before control transfers.
// - vectors 0003h, 000bh, 0013h, 001bh, 0023h, 002bh for classic sources.
// - vectors 0033h, 003bh, 0043h, 0053h, 005bh for added sources.
// - with watchdog select set, timeout raises an interrupt, not reset.
// - the watchdog interrupt is always high priority.
// - the global enable never masks the watchdog interrupt.
// - the watchdog interrupts only when its timeout value exceeds zero.
// - primary bit 7 clear disables every maskable source.
// - eleven request sources served over two priority levels.
module pic_priority_interrupt_controller
  import pic_pkg::*;
(
  input  wire logic        aclk,                    // core clock
  input  wire logic        aresetn,                 // sync reset, low active
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,            // write address
  input  wire logic        s_axi_awvalid,           // write address valid
  output logic             s_axi_awready,           // write address ready
  input  wire logic [31:0] s_axi_wdata,             // write data
  input  wire logic [3:0]  s_axi_wstrb,             // write byte strobes
  input  wire logic        s_axi_wvalid,            // write data valid
  output logic             s_axi_wready,            // write data ready
  output logic [1:0]       s_axi_bresp,             // write response
  output logic             s_axi_bvalid,            // write response valid
  input  wire logic        s_axi_bready,            // write response ready
  input  wire logic [7:0]  s_axi_araddr,            // read address
  input  wire logic        s_axi_arvalid,           // read address valid
  output logic             s_axi_arready,           // read address ready
  output logic [31:0]      s_axi_rdata,             // read data
  output logic [1:0]       s_axi_rresp,             // read response
  output logic             s_axi_rvalid,            // read data valid
  input  wire logic        s_axi_rready,            // read data ready
  // peripheral request flags, levels held by their owners
  input  wire logic        supply_monitor_flag,     // supply monitor
  input  wire logic        ext0_flag,               // external 0
  input  wire logic [1:0]  adc_ready_flags,         // adc ready pair
  input  wire logic        timer0_overflow,         // timer 0
  input  wire logic        ext1_flag,               // external 1
  input  wire logic        timer1_overflow,         // timer 1
  input  wire logic        spi_flag,                // spi port
  input  wire logic [1:0]  uart_rx_tx_flags,        // uart rx and tx
  input  wire logic [1:0]  timer2_flags,            // timer 2 pair
  input  wire logic        interval_counter_flag,   // interval counter
  input  wire logic        watchdog_timeout,        // watchdog expiry pulse
  output logic             watchdog_reset,          // device reset pulse
  // processor core side
  output logic             irq_req,                 // interrupt offered
  input  wire logic        irq_ack,                 // core takes the offer
  output logic             pc_push,                 // push pc to stack
  output logic             pc_load,                 // load pc from vector
  output logic [15:0]      irq_vector,              // vector address
  input  wire logic        reti                     // return from service
);

  ////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0]    prim_en_q, prim_pri_q, sec_q, wd_cfg_q;
  logic          wd_flag_q;
  logic          in_hi_q, in_lo_q;
  pic_state_type state_q;
  logic [15:0]   vec_q;
  logic [3:0]    win_idx_q;
  logic          win_hi_q;
  logic          wd_reset_q;
  logic          bvalid_q, rvalid_q;
  logic [1:0]    bresp_q, rresp_q;
  logic [31:0]   rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // axi write decode; address and data are taken together
  wire        wr_take   = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire        wr_lane0  = s_axi_wstrb[0];
  wire [7:0]  wr_byte   = s_axi_wdata[7:0];
  wire        wr_pe     = wr_take && wr_lane0 && (s_axi_awaddr == PIC_PRIMARY_ENABLE_OFS);
  wire        wr_pp     = wr_take && wr_lane0 && (s_axi_awaddr == PIC_PRIMARY_PRIORITY_OFS);
  wire        wr_sec    = wr_take && wr_lane0 && (s_axi_awaddr == PIC_SECONDARY_OFS);
  wire        wr_wd     = wr_take && wr_lane0 && (s_axi_awaddr == PIC_WATCHDOG_CFG_OFS);
  wire        wr_map    = (s_axi_awaddr == PIC_PRIMARY_ENABLE_OFS)
                       || (s_axi_awaddr == PIC_PRIMARY_PRIORITY_OFS)
                       || (s_axi_awaddr == PIC_SECONDARY_OFS)
                       || (s_axi_awaddr == PIC_WATCHDOG_CFG_OFS)
                       || (s_axi_awaddr == PIC_STATUS_OFS);
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // reserved bits keep their reset value; bit 3 never stores a one
  wire [7:0] sec_wr_val = (wr_byte & PIC_SEC_WRITE_MASK)
                        | (PIC_SECONDARY_RST & ~PIC_SEC_WRITE_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prim_en_q  <= PIC_PRIMARY_ENABLE_RST;
      prim_pri_q <= PIC_PRIMARY_PRIORITY_RST;
      sec_q      <= PIC_SECONDARY_RST;
      wd_cfg_q   <= PIC_WATCHDOG_CFG_RST;
    end else begin
      if (wr_pe)  prim_en_q  <= wr_byte;
      if (wr_pp)  prim_pri_q <= wr_byte & PIC_PRIO_WRITE_MASK;
      if (wr_sec) sec_q      <= sec_wr_val;
      if (wr_wd)  wd_cfg_q   <= wr_byte & PIC_WD_WRITE_MASK;
    end
  end

  // write response one cycle after the take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= PIC_RESP_OKAY;
    end else if (wr_take) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_map ? PIC_RESP_OKAY : PIC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi read path; status shows live controller state
  // status is a debug view only, so software should not poll it for dispatch
  wire        rd_take = s_axi_arvalid && !rvalid_q;
  wire [31:0] status_word = {vec_q, 4'h0, win_idx_q, 2'b00, state_q,
                             wd_flag_q, win_hi_q, in_hi_q, in_lo_q};
  wire [31:0] rd_word =
      (s_axi_araddr == PIC_PRIMARY_ENABLE_OFS)   ? {24'h000000, prim_en_q}  :
      (s_axi_araddr == PIC_PRIMARY_PRIORITY_OFS) ? {24'h000000, prim_pri_q} :
      (s_axi_araddr == PIC_SECONDARY_OFS)        ? {24'h000000, sec_q}      :
      (s_axi_araddr == PIC_WATCHDOG_CFG_OFS)     ? {24'h000000, wd_cfg_q}   :
      (s_axi_araddr == PIC_STATUS_OFS)           ? status_word : 32'h00000000;
  wire        rd_map  = (s_axi_araddr == PIC_PRIMARY_ENABLE_OFS)
                     || (s_axi_araddr == PIC_PRIMARY_PRIORITY_OFS)
                     || (s_axi_araddr == PIC_SECONDARY_OFS)
                     || (s_axi_araddr == PIC_WATCHDOG_CFG_OFS)
                     || (s_axi_araddr == PIC_STATUS_OFS);
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= PIC_RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_map ? PIC_RESP_OKAY : PIC_RESP_SLVERR;
      rdata_q  <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog expiry: interrupt or reset, chosen by the select bit
  wire wd_timeout_nz = (wd_cfg_q[PIC_WD_TIMEOUT_LSB +: PIC_WD_TIMEOUT_W] != '0);
  wire wd_irq_mode   = wd_cfg_q[PIC_WD_SELECT_BIT];
  wire wd_set        = watchdog_timeout && wd_irq_mode && wd_timeout_nz;
  wire wd_clr        = (state_q == PIC_LOAD) && (win_idx_q == 4'(PIC_SRC_WDOG));

  // a timeout in the clearing cycle stays pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_flag_q  <= 1'b0;
      wd_reset_q <= 1'b0;
    end else begin
      wd_flag_q  <= wd_set || (wd_flag_q && !wd_clr);
      wd_reset_q <= watchdog_timeout && !wd_irq_mode;
    end
  end
  assign watchdog_reset = wd_reset_q;

  ////////////////////////////////////////////////////////////////////////
  // per-source request, enable and level in polling order
  // paired flags are ORed, so either half of a pair raises its source
  wire global_en = prim_en_q[PIC_PRI_GLOBAL_BIT];
  wire [PIC_NSRC-1:0] src_req = {
    interval_counter_flag, |timer2_flags, |uart_rx_tx_flags, spi_flag,
    timer1_overflow, ext1_flag, timer0_overflow, |adc_ready_flags,
    ext0_flag, wd_flag_q, supply_monitor_flag};
  wire [PIC_NSRC-1:0] src_en = {
    sec_q[PIC_SEC_TIC_EN_BIT],
    prim_en_q[PIC_PRI_TIMER2_BIT], prim_en_q[PIC_PRI_UART_BIT],
    sec_q[PIC_SEC_SPI_EN_BIT],
    prim_en_q[PIC_PRI_TIMER1_BIT], prim_en_q[PIC_PRI_EXT1_BIT],
    prim_en_q[PIC_PRI_TIMER0_BIT], prim_en_q[PIC_PRI_ADC_BIT],
    prim_en_q[PIC_PRI_EXT0_BIT], 1'b1,
    sec_q[PIC_SEC_PSM_EN_BIT]};
  wire [PIC_NSRC-1:0] src_hi = {
    sec_q[PIC_SEC_TIC_PRI_BIT],
    prim_pri_q[PIC_PRI_TIMER2_BIT], prim_pri_q[PIC_PRI_UART_BIT],
    sec_q[PIC_SEC_SPI_PRI_BIT],
    prim_pri_q[PIC_PRI_TIMER1_BIT], prim_pri_q[PIC_PRI_EXT1_BIT],
    prim_pri_q[PIC_PRI_TIMER0_BIT], prim_pri_q[PIC_PRI_ADC_BIT],
    prim_pri_q[PIC_PRI_EXT0_BIT], 1'b1,
    sec_q[PIC_SEC_PSM_PRI_BIT]};

  // eligible sources; the watchdog bypasses the global enable
  wire [PIC_NSRC-1:0] elig;
  genvar gi;
  generate
    for (gi = 0; gi < PIC_NSRC; gi++) begin : g_elig
      if (gi == PIC_SRC_WDOG) begin : g_wd
        assign elig[gi] = src_req[gi];
      end else begin : g_mask
        assign elig[gi] = src_req[gi] && src_en[gi] && global_en;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // level selection and fixed-order pick
  // a pending low request waits while any high one is eligible
  wire [PIC_NSRC-1:0] elig_hi  = elig & src_hi;
  wire [PIC_NSRC-1:0] elig_lo  = elig & ~src_hi;
  wire                take_hi  = (|elig_hi) && !in_hi_q;
  wire                take_lo  = (|elig_lo) && !in_hi_q && !in_lo_q
                                 && !(|elig_hi);
  wire [PIC_NSRC-1:0] cand     = take_hi ? elig_hi : elig_lo;

  // lowest index wins, which is the polling order
  logic [3:0] pick_idx;
  always_comb begin
    pick_idx = 4'h0;
    for (int i = PIC_NSRC - 1; i >= 0; i--) begin
      if (cand[i]) pick_idx = 4'(i);
    end
  end
  wire [15:0] pick_vec = PIC_VECTORS[pick_idx];

  ////////////////////////////////////////////////////////////////////////
  // dispatch sequencer: offer, push pc, then load vector
  // the offer is frozen once made, so the vector cannot change under the core
  logic [1:0] state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PIC_IDLE:  if (take_hi || take_lo) state_d = PIC_OFFER;
      PIC_OFFER: if (irq_ack) state_d = PIC_PUSH;
      PIC_PUSH:  state_d = PIC_LOAD;
      PIC_LOAD:  state_d = PIC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= PIC_IDLE;
      vec_q     <= 16'h0000;
      win_idx_q <= 4'h0;
      win_hi_q  <= 1'b0;
    end else begin
      state_q <= pic_state_type'(state_d);
      if (state_q == PIC_IDLE && (take_hi || take_lo)) begin
        vec_q     <= pick_vec;
        win_idx_q <= pick_idx;
        win_hi_q  <= take_hi;
      end
    end
  end

  // in-service levels; return closes the high level first
  // a return in the load cycle would be lost; the core cannot issue one there
  wire enter_svc = (state_q == PIC_LOAD);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_hi_q <= 1'b0;
      in_lo_q <= 1'b0;
    end else if (enter_svc) begin
      if (win_hi_q) in_hi_q <= 1'b1;
      else          in_lo_q <= 1'b1;
    end else if (reti) begin
      if (in_hi_q) in_hi_q <= 1'b0;
      else         in_lo_q <= 1'b0;
    end
  end

  // core-side outputs
  assign irq_req    = (state_q == PIC_OFFER);
  assign pc_push    = (state_q == PIC_PUSH);
  assign pc_load    = (state_q == PIC_LOAD);
  assign irq_vector = vec_q;

endmodule

`default_nettype wire

// ===== testbench/pic_priority_interrupt_controller_assertions.sv
// port checker for the priority interrupt controller
`timescale 1ns/1ns
`default_nettype none
module pic_checker (
  input wire logic        aclk,             // clock
  input wire logic        aresetn,          // sync reset
  input wire logic [1:0]  s_axi_bresp,      // write code
  input wire logic        s_axi_bvalid,     // write answer
  input wire logic        s_axi_bready,     // write accept
  input wire logic        s_axi_arvalid,    // read request
  input wire logic        s_axi_arready,    // read taken
  input wire logic [31:0] s_axi_rdata,      // read data
  input wire logic        s_axi_rvalid,     // read answer
  input wire logic        s_axi_rready,     // read accept
  input wire logic        watchdog_timeout, // expiry pulse
  input wire logic        watchdog_reset,   // reset pulse
  input wire logic        irq_req,          // offer
  input wire logic        irq_ack,          // offer taken
  input wire logic        pc_push,          // push pulse
  input wire logic        pc_load,          // load pulse
  input wire logic [15:0] irq_vector        // vector
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////
  // push must come first, then the load, with the push a single cycle
  sequence s_push_load;
    pc_push ##1 (pc_load && !pc_push);
  endsequence
  AST_ACK_PUSH: assert property (irq_req && irq_ack |=> s_push_load)
    else $error("push and load did not follow the ack");
  AST_PUSH_CAUSE: assert property (pc_push |-> $past(irq_ack) && $past(irq_req))
    else $error("push without a taken offer");
  AST_OFFER_HOLD: assert property (irq_req && !irq_ack |=> irq_req && $stable(irq_vector))
    else $error("offer dropped or vector moved");
  AST_VEC_SET: assert property (irq_req |-> irq_vector inside {16'h0003, 16'h000b,
    16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h0053, 16'h005b})
    else $error("vector outside the fixed set");
  AST_WD_RESET: assert property (watchdog_reset |-> $past(watchdog_timeout))
    else $error("device reset without a watchdog expiry");
  //////////////////////////////////////////
  // bus answers stand until accepted; a taken read is answered the next cycle
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer withdrawn");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer withdrawn");
  AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read taken but not answered");
endmodule
bind pic_priority_interrupt_controller pic_checker i_chk (.aclk, .aresetn, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .watchdog_timeout, .watchdog_reset, .irq_req, .irq_ack, .pc_push, .pc_load,
  .irq_vector);
`default_nettype wire

// ===== testbench/pic_core_model.sv
// behavioural processor core that takes interrupt offers
`timescale 1ns/1ns
`default_nettype none
module pic_core_model (
  input  wire logic        aclk,       // core clock
  input  wire logic        aresetn,    // sync reset
  input  wire logic        irq_req,    // offer
  input  wire logic        pc_push,    // push pulse
  input  wire logic        pc_load,    // load pulse
  input  wire logic [15:0] irq_vector, // vector
  input  wire logic [3:0]  ack_dly,    // wait before ack
  input  wire logic        ret_req,    // bench asks for return
  output logic             irq_ack,    // offer taken
  output logic             reti,       // return pulse
  output logic [7:0]       taken_cnt,  // vectors loaded
  output logic [15:0]      taken_vec   // last vector loaded
);
  logic [3:0] wait_q;
  logic       pushed_q;
  // slow or prompt ack; a load only counts after its push
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {irq_ack, reti, pushed_q, wait_q, taken_cnt, taken_vec} <= '0;
    end else begin
      wait_q <= (irq_req && !irq_ack) ? wait_q + 4'h1 : 4'h0;
      irq_ack <= irq_req && !irq_ack && (wait_q >= ack_dly);
      reti <= ret_req;
      if (pc_push) pushed_q <= 1'b1;
      if (pc_load && pushed_q) begin
        taken_cnt <= taken_cnt + 8'h01;
        taken_vec <= irq_vector;
        pushed_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/test_priority_interrupt_controller.sv
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ns
`default_nettype none
module test_priority_interrupt_controller;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, wd_to = 1'b0, ret_req = 1'b0, alt = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cnt;
  logic [31:0] wdata = 32'h0, rdata, exp_n = 32'h0;
  logic [3:0] dly = 4'h0, strb = 4'hf;
  logic [10:0] fl = 11'h000;
  logic awready, wready, bvalid, arready, rvalid, wd_rst, irq_req, irq_ack, pc_push, pc_load, reti;
  logic [1:0] bresp, rresp;
  logic [15:0] irq_vector, tvec;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  // reset rows: response, address, value; last is unmapped
  logic [17:0] rst_tab [6] = '{18'h0_00_00, 18'h0_04_00, 18'h0_08_a0, 18'h0_0c_00, 18'h0_10_00,
    18'h2_14_00};
  // source rows: index, primary enable, secondary, vector
  logic [35:0] rows [10] = '{36'h0_80_02_0043, 36'h2_81_00_0003, 36'h3_c0_00_0033,
    36'h4_82_00_000b, 36'h5_84_00_0013, 36'h6_88_00_001b, 36'h7_80_01_003b,
    36'h8_90_00_0023, 36'h9_a0_00_002b, 36'ha_80_04_0053};
  logic [7:0] sec_tab [3] = '{8'h11, 8'h22, 8'h44};
  int src_tab [3] = '{7, 0, 10};
  // paired flags alternate their halves so both inputs get used
  pic_priority_interrupt_controller i_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .supply_monitor_flag(fl[0]), .ext0_flag(fl[2]),
    .adc_ready_flags({fl[3] & alt, fl[3] & !alt}), .timer0_overflow(fl[4]), .ext1_flag(fl[5]),
    .timer1_overflow(fl[6]), .spi_flag(fl[7]), .uart_rx_tx_flags({fl[8] & alt, fl[8] & !alt}),
    .timer2_flags({fl[9] & alt, fl[9] & !alt}), .interval_counter_flag(fl[10]),
    .watchdog_timeout(wd_to), .watchdog_reset(wd_rst), .irq_req, .irq_ack, .pc_push, .pc_load,
    .irq_vector, .reti);
  pic_core_model i_core (.aclk, .aresetn, .irq_req, .pc_push, .pc_load, .irq_vector,
    .ack_dly(dly), .ret_req, .irq_ack, .reti, .taken_cnt(cnt), .taken_vec(tvec));
  initial forever #4 aclk = ~aclk;
  //////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic axi_wr(logic [7:0] a, logic [31:0] v);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'b11};
    do @(posedge aclk); while (!(awready && wready));
    {awvalid, wvalid, bready} <= 3'b001;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("write code", {30'h0, ((a > 8'h10) ? 2'b10 : 2'b00)}, {30'h0, bresp});
  endtask
  task automatic axi_rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    @(posedge aclk);
    {araddr, arvalid} <= {a, 1'b1};
    do @(posedge aclk); while (!arready);
    {arvalid, rready} <= 2'b01;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("read data", e, rdata);
    chk("read code", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic src(int i, logic v);
    @(posedge aclk);
    fl[i] <= v;
  endtask
  // counts stay absolute, so a dispatch during a bus write is not lost
  task automatic take(logic [15:0] e);
    exp_n++;
    for (int n = 0; n < 80 && cnt !== exp_n[7:0]; n++) @(posedge aclk);
    chk("dispatch count", exp_n, {24'h0, cnt});
    chk("vector", {16'h0, e}, {16'h0, tvec});
  endtask
  task automatic none();
    repeat (30) @(posedge aclk);
    chk("dispatch count", exp_n, {24'h0, cnt});
  endtask
  task automatic ret();
    @(posedge aclk);
    {ret_req, alt} <= {1'b1, !alt};
    @(posedge aclk);
    ret_req <= 1'b0;
  endtask
  task automatic wd();
    @(posedge aclk);
    wd_to <= 1'b1;
    @(posedge aclk);
    wd_to <= 1'b0;
    @(posedge aclk);
  endtask
  //////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rst_tab[i]) axi_rd(rst_tab[i][15:8], {24'h0, rst_tab[i][7:0]}, rst_tab[i][17:16]);
    // lane 0 off leaves the register alone; an unmapped write answers an error
    strb <= 4'he;
    axi_wr(8'h08, 32'h77);
    strb <= 4'hf;
    axi_rd(8'h08, 32'ha0, 2'b00);
    axi_wr(8'h14, 32'hff);
    axi_wr(8'h08, 32'h77);
    axi_rd(8'h08, 32'hf7, 2'b00);
    foreach (rows[i]) begin
      axi_wr(8'h00, {24'h0, rows[i][31:24]});
      axi_wr(8'h08, {24'h0, rows[i][23:16]});
      src(rows[i][35:32], 1'b1);
      take(rows[i][15:0]);
      src(rows[i][35:32], 1'b0);
      ret();
    end
    // every maskable source at one level at once
    axi_wr(8'h00, 32'hff);
    axi_wr(8'h08, 32'h07);
    @(posedge aclk);
    fl <= 11'h7fd;
    for (int i = 0; i < 11; i++) begin
      if (i != 1) begin
        take(pic_pkg::PIC_VECTORS[i]);
        src(i, 1'b0);
        ret();
      end
    end
    // global enable off, then nesting across the two levels
    axi_wr(8'h00, 32'h07);
    axi_wr(8'h04, 32'h02);
    src(2, 1'b1);
    none();
    axi_wr(8'h00, 32'h87);
    take(16'h0003);
    src(2, 1'b0);
    src(5, 1'b1);
    none();
    src(4, 1'b1);
    take(16'h000b);
    src(4, 1'b0);
    ret();
    none();
    ret();
    take(16'h0013);
    src(5, 1'b0);
    ret();
    @(posedge aclk);
    fl <= 11'h034;
    take(16'h000b);
    src(2, 1'b0);
    src(5, 1'b0);
    src(4, 1'b0);
    ret();
    // secondary priority bits lift a source over a low routine
    foreach (sec_tab[k]) begin
      axi_wr(8'h00, 32'h81);
      axi_wr(8'h08, {24'h0, sec_tab[k]});
      src(2, 1'b1);
      take(16'h0003);
      src(2, 1'b0);
      src(src_tab[k], 1'b1);
      take(pic_pkg::PIC_VECTORS[src_tab[k]]);
      src(src_tab[k], 1'b0);
      ret();
      ret();
    end
    // watchdog: reset when not selected, else an unmaskable high interrupt if its timeout is nonzero
    axi_wr(8'h0c, 32'h00);
    wd();
    chk("watchdog reset", 32'h1, {31'h0, wd_rst});
    none();
    dly <= 4'h3;
    axi_wr(8'h0c, 32'h11);
    src(2, 1'b1);
    take(16'h0003);
    src(2, 1'b0);
    axi_wr(8'h00, 32'h01);
    wd();
    chk("watchdog reset", 32'h0, {31'h0, wd_rst});
    take(16'h005b);
    ret();
    ret();
    axi_wr(8'h0c, 32'h01);
    wd();
    none();
    complete_run();
  end
endmodule
`default_nettype wire
